// *** include/acr_map.vh ***
// Function
// - ten-bit signed phase trim, bits 15:6, reset zero
// - configuration bits 5:3 always read zero
// - bit 2 bypasses DC filter for channel
// - bits 1:0 select channel input source
// - offset high holds offset bits 23:8
// - offset low upper byte holds bits 7:0
// - gain high holds unsigned gain bits 23:8
// - gain low upper byte holds bits 7:0
// - low byte of low registers reads zero
// - gain high resets 8000h, others zero
// - global DC filter setting, 4-bit, reset zero
`ifndef ACR_MAP_VH
`define ACR_MAP_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define ACR_ADDR_W 8
`define ACR_CFG_ADDR 8'h0e
`define ACR_OFS_HI_ADDR 8'h0f
`define ACR_OFS_LO_ADDR 8'h10
`define ACR_GAIN_HI_ADDR 8'h11
`define ACR_GAIN_LO_ADDR 8'h12
`define ACR_GLOBAL_ADDR 8'h20
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define ACR_PHASE_MSB 15
`define ACR_PHASE_LSB 6
`define ACR_BYPASS_BIT 2
`define ACR_SEL_MSB 1
`define ACR_SEL_LSB 0
`define ACR_CFG_RST 16'h0000
`define ACR_OFS_HI_RST 16'h0000
`define ACR_BYTE_RST 8'h00
`define ACR_GAIN_HI_RST 16'h8000
`define ACR_GLOBAL_RST 4'h0
`define ACR_ZERO16 16'h0000
`define ACR_SEL_OWN 2'h0
`define ACR_SEL_SHORT 2'h1
`define ACR_SEL_POS 2'h2
`define ACR_SEL_NEG 2'h3
`endif

// *** rtl/acr_word_join.v ***
`timescale 1ns/1ps
// ----------------------------------------
// registered 24-bit calibration word assembly
// ----------------------------------------
module acr_word_join (
  input wire i_clock,
  input wire i_nrst,
  input wire [15:0] i_high,
  input wire [7:0] i_low,
  input wire [23:0] i_rst_val,
  output reg [23:0] o_word
);
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      o_word <= i_rst_val;
    end else begin
      o_word <= {i_high, i_low};
    end
  end
endmodule

// *** rtl/acr_channel_regs.v ***
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "acr_map.vh"
module acr_channel_regs (
  input wire i_clock,
  input wire i_nrst,
  input wire [7:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [15:0] o_rdata,
  output reg [9:0] o_phase_trim,
  output reg o_dc_filter_en,
  output reg [1:0] o_input_select,
  output reg [3:0] o_global_dc_filter_setting,
  output wire [23:0] o_offset_word,
  output wire [23:0] o_gain_word
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [9:0] phase_trim_r;
  reg dc_filter_bypass_r;
  reg [1:0] input_select_r;
  reg [15:0] offset_word_high_r;
  reg [7:0] offset_word_low_r;
  reg [15:0] gain_word_high_r;
  reg [7:0] gain_word_low_r;
  reg [3:0] global_setting_r;
  reg [15:0] rdata_nxt;

  always @(posedge i_clock) begin
    if (!i_nrst) begin
      phase_trim_r <= 10'h000;
      dc_filter_bypass_r <= 1'b0;
      input_select_r <= `ACR_SEL_OWN;
      offset_word_high_r <= `ACR_OFS_HI_RST;
      offset_word_low_r <= `ACR_BYTE_RST;
      gain_word_high_r <= `ACR_GAIN_HI_RST;
      gain_word_low_r <= `ACR_BYTE_RST;
      global_setting_r <= `ACR_GLOBAL_RST;
    end else if (i_wr) begin
      case (i_addr)
        `ACR_CFG_ADDR: begin
          phase_trim_r <= i_wdata[`ACR_PHASE_MSB:`ACR_PHASE_LSB];
          dc_filter_bypass_r <= i_wdata[`ACR_BYPASS_BIT];
          input_select_r <= i_wdata[`ACR_SEL_MSB:`ACR_SEL_LSB];
        end
        `ACR_OFS_HI_ADDR: offset_word_high_r <= i_wdata;
        `ACR_OFS_LO_ADDR: offset_word_low_r <= i_wdata[15:8];
        `ACR_GAIN_HI_ADDR: gain_word_high_r <= i_wdata;
        `ACR_GAIN_LO_ADDR: gain_word_low_r <= i_wdata[15:8];
        `ACR_GLOBAL_ADDR: global_setting_r <= i_wdata[3:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // read path; unmapped addresses read zero
  // ----------------------------------------
  always @* begin
    case (i_addr)
      `ACR_CFG_ADDR: rdata_nxt = {phase_trim_r, 3'b000, dc_filter_bypass_r,
                                  input_select_r};
      `ACR_OFS_HI_ADDR: rdata_nxt = offset_word_high_r;
      `ACR_OFS_LO_ADDR: rdata_nxt = {offset_word_low_r, `ACR_BYTE_RST};
      `ACR_GAIN_HI_ADDR: rdata_nxt = gain_word_high_r;
      `ACR_GAIN_LO_ADDR: rdata_nxt = {gain_word_low_r, `ACR_BYTE_RST};
      `ACR_GLOBAL_ADDR: rdata_nxt = {12'h000, global_setting_r};
      default: rdata_nxt = `ACR_ZERO16;
    endcase
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      o_rdata <= `ACR_ZERO16;
      o_phase_trim <= 10'h000;
      o_dc_filter_en <= 1'b0;
      o_input_select <= `ACR_SEL_OWN;
      o_global_dc_filter_setting <= `ACR_GLOBAL_RST;
    end else begin
      // read data held only in the cycle after the strobe
      o_rdata <= i_rd ? rdata_nxt : `ACR_ZERO16;
      o_phase_trim <= phase_trim_r;
      // filter runs when global setting is nonzero and channel not bypassed
      o_dc_filter_en <= ~dc_filter_bypass_r & (|global_setting_r);
      o_input_select <= input_select_r;
      o_global_dc_filter_setting <= global_setting_r;
    end
  end

  acr_word_join u_offset_join (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_high(offset_word_high_r),
    .i_low(offset_word_low_r),
    .i_rst_val(24'h00_0000),
    .o_word(o_offset_word)
  );

  acr_word_join u_gain_join (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_high(gain_word_high_r),
    .i_low(gain_word_low_r),
    .i_rst_val(24'h80_0000),
    .o_word(o_gain_word)
  );
endmodule

// *** tb/acr_chk_properties.sv ***
`timescale 1ns/1ps
module acr_chk (
  input wire i_clock, i_nrst, i_wr, i_rd, o_dc_filter_en,
  input wire [7:0] i_addr,
  input wire [15:0] i_wdata, o_rdata,
  input wire [9:0] o_phase_trim,
  input wire [1:0] o_input_select,
  input wire [23:0] o_offset_word, o_gain_word
);
  wire cw = i_wr && i_addr == 8'h0e;
  wire rl = i_rd && (i_addr == 8'h10 || i_addr == 8'h12);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  a_cfg_resv: assert property (i_rd && i_addr == 8'h0e |=> o_rdata[5:3] == 3'h0)
    else $error("cfg reserved set");
  a_low_resv: assert property (rl |=> o_rdata[7:0] == 8'h00)
    else $error("low byte set");
  a_phase_map: assert property (cw |=> ##1 o_phase_trim == $past(i_wdata[15:6], 2))
    else $error("phase wrong");
  a_bypass_off: assert property (cw && i_wdata[2] |=> ##1 !o_dc_filter_en)
    else $error("filter on");
  a_sel_map: assert property (cw |=> ##1 o_input_select == $past(i_wdata[1:0], 2))
    else $error("select wrong");
  a_ofs_high: assert property (i_wr && i_addr == 8'h0f |=> ##1
    o_offset_word[23:8] == $past(i_wdata, 2)) else $error("offset wrong");
  a_gain_high: assert property (i_wr && i_addr == 8'h11 |=> ##1
    o_gain_word[23:8] == $past(i_wdata, 2)) else $error("gain wrong");
  a_rst_val: assert property ($rose(i_nrst) |-> o_gain_word == 24'h80_0000 &&
    o_offset_word == 24'h00_0000) else $error("reset words wrong");
endmodule

// *** tb/acr_channel_regs_tb_top.sv ***
`timescale 1ns/1ps
module acr_channel_regs_tb_top;
  logic i_clock = 0, i_nrst = 0, i_wr = 0, i_rd = 0, rd_d = 0;
  logic [7:0] i_addr = 0;
  logic [15:0] i_wdata = 0, q [$], m [0:255];
  logic [31:0] rs = 32'h0000_0058;
  // 8'h13 is unmapped: writes vanish, reads give zero
  logic [7:0] ad [7] = '{8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h20, 8'h13};
  wire [15:0] o_rdata;
  wire [9:0] o_phase_trim;
  wire o_dc_filter_en;
  wire [1:0] o_input_select;
  wire [3:0] o_global_dc_filter_setting;
  wire [23:0] o_offset_word, o_gain_word;
  int miscompares = 0, checked = 0;
  acr_channel_regs i_dut (.*);
  always #12.5 i_clock = ~i_clock;
  task chk(input logic [23:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    if (miscompares == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // strobes hold until the next call, so back-to-back calls keep each strobe high for one cycle
  task bus(input logic w, r, input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clock);
    {i_wr, i_rd, i_addr, i_wdata} <= {w, r, a, d};
    if (r) q.push_back(d);
  endtask
  function logic [15:0] msk(input logic [7:0] a, input logic [15:0] d);
    msk = a == 8'h0e ? d & 16'hffc7 : a == 8'h10 || a == 8'h12 ? d & 16'hff00 :
      a == 8'h20 ? d & 16'h000f : a == 8'h13 ? 16'h0000 : d;
  endfunction
  function logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    xs = x ^ (x << 5);
  endfunction
  always @(posedge i_clock) begin
    if (rd_d) chk(o_rdata, q.pop_front());
    rd_d <= i_rd;
  end
  initial begin
    #20us;
    miscompares++;
    end_sim;
  end
  initial begin
    repeat (2) @(posedge i_clock);
    i_nrst <= 1;
    foreach (ad[k]) bus(0, 1, ad[k], ad[k] == 8'h11 ? 16'h8000 : 16'h0000);
    repeat (3) foreach (ad[k]) begin
      rs = xs(rs);
      m[ad[k]] = msk(ad[k], rs[15:0]);
      bus(1, 0, ad[k], rs[15:0]);
      bus(0, 1, ad[k], m[ad[k]]);
    end
    repeat (3) bus(0, 0, 0, 0);
    #1;
    chk(o_offset_word, {m[8'h0f], m[8'h10][15:8]});
    chk(o_gain_word, {m[8'h11], m[8'h12][15:8]});
    chk(o_phase_trim, m[8'h0e][15:6]);
    chk(o_global_dc_filter_setting, m[8'h20]);
    bus(1, 0, 8'h20, 16'h0005);
    for (int s = 0; s < 8; s++) begin
      bus(1, 0, 8'h0e, 16'(s));
      repeat (2) bus(0, 0, 0, 0);
      #1;
      chk(o_input_select, s[1:0]);
      chk(o_dc_filter_en, !s[2]);
    end
    end_sim;
  end
endmodule
bind acr_channel_regs acr_chk i_chk (.*);
